//--- rtl/sepc_cfg.svh
// constants of the spi eeprom command and protection front end
`ifndef SEPC_CFG_SVH
`define SEPC_CFG_SVH

// opcodes
`define SEPC_OP_SET_WL 8'h06
`define SEPC_OP_CLR_WL 8'h04
`define SEPC_OP_ST_RD 8'h05
`define SEPC_OP_ST_WR 8'h01
`define SEPC_OP_MEM_RD 8'h03
`define SEPC_OP_MEM_WR 8'h02

// status bit positions
`define SEPC_ST_GUARD_EN 7
`define SEPC_ST_ID_SEL 6
`define SEPC_ST_ZERO 5
`define SEPC_ST_ID_LOCK 4
`define SEPC_ST_GUARD_HI 3
`define SEPC_ST_GUARD_LO 2
`define SEPC_ST_PERMIT 1
`define SEPC_ST_BUSY 0

// reset value of the status register
`define SEPC_STATUS_RST 8'h00

// protected region starts
`define SEPC_QUARTER_BASE 16'hc000
`define SEPC_HALF_BASE 16'h8000

// frame bit indices
`define SEPC_OP_LAST 6'h07
`define SEPC_ADDR_FIRST 6'h08
`define SEPC_SW_LAST 6'h0f
`define SEPC_ADDR_LAST 6'h17
`define SEPC_CNT_MAX 6'h3f

// timing: core clock period and self-timed write time in ns
`define SEPC_CLK_NS 8
`define SEPC_TWC_NS 4000000
`define SEPC_TCNT_W 24

`endif

//--- rtl/sepc_pkg.sv
// types of the spi eeprom command and protection front end
package sepc_pkg;

	// status register layout, bit 7 down to bit 0
	typedef struct packed {
		logic guard_en;
		logic id_sel;
		logic zero;
		logic id_lock;
		logic [1:0] guard;
		logic permit;
		logic busy;
	} sepc_status_t;

	// one accepted write byte handed to the array
	typedef struct packed {
		logic id;
		logic [15:0] addr;
		logic [7:0] data;
	} sepc_mem_wr_t;

	// core clock state
	typedef struct packed {
		logic cs_s1;
		logic cs_s2;
		logic cs_prev;
		logic wp_s1;
		logic wp_s2;
		logic tg_s1;
		logic tg_s2;
		logic tg_prev;
		sepc_status_t st;
		logic skip_frame;
		logic acc_any;
		logic [23:0] tcnt;
		sepc_mem_wr_t mem_wr;
		logic mem_wr_valid;
		logic commit;
	} sepc_core_st_t;

	// serial clock rising edge state
	typedef struct packed {
		logic [5:0] cnt;
		logic [2:0] bpos;
		logic [6:0] sh;
		logic [7:0] op;
		logic [15:0] addr;
		logic [7:0] sw_data;
		logic [7:0] wr_data;
		logic [15:0] wr_addr;
		logic wr_tog;
		logic load;
		logic drive;
		logic [7:0] st_s1;
		logic [7:0] st_s2;
	} sepc_link_st_t;

	// serial clock falling edge state
	typedef struct packed {
		logic [7:0] sh;
		logic oe;
	} sepc_out_st_t;

endpackage : sepc_pkg

//--- rtl/sepc_top.sv
// spi eeprom slave front end: serial framing, opcodes, status and write protection
//
// Contract
// - sample serial input on rising clock edge
// - change serial output on falling clock edge
// - output off while chip select high
// - pin low plus enable refuses status writes
// - first eight bits form opcode; unknown ignored
// - opcodes for latch set, clear, status write
// - opcodes for status read, memory read, write
// - memory write needs latch; read needs address
// - page select steers access to id page
// - busy shows self-timed write, host cannot alter
// - latch set and cleared by its opcodes
// - block guard bits gate array writes
// - guard encoding: none, quarter, half, all
// - hardware guard blocks status and guarded memory
// - hardware guard off when pin high/enable 0
// - page select volatile, clears after access
// - page lock refuses id page writes until reset
// - setting select and lock together changes neither
// - status bit layout fixed, bit 5 zero
// - self-timed write starts at closing chip select
// - while busy only status read acts
// - status write changes bits 7,6,4,3,2 only
// - memory opcodes take a 16-bit address
// - write address wraps inside 128-byte page
`timescale 1ns/1ps
`include "sepc_cfg.svh"

module sepc_top
	import sepc_pkg::*;
#(
	parameter int unsigned TWC_CYCLES = `SEPC_TWC_NS / `SEPC_CLK_NS
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	input wire logic spi_hold_n,
	input wire logic spi_wp_n,
	output logic spi_so_o,
	output logic spi_so_oe,
	output logic [15:0] mem_rd_addr,
	output logic mem_rd_id,
	input wire logic [7:0] mem_rd_data,
	output sepc_mem_wr_t mem_wr,
	output logic mem_wr_valid,
	output logic mem_commit,
	output sepc_status_t status_o
);

	sepc_core_st_t core_r;
	sepc_core_st_t core_nxt;
	sepc_link_st_t link_r;
	sepc_link_st_t link_nxt;
	sepc_out_st_t out_r;
	sepc_out_st_t out_nxt;
	logic armed_r;
	logic frame_rst_n;

	// true when an array address falls in the guarded block
	function automatic logic sepc_guarded(input logic [1:0] guard, input logic [15:0] addr);
		logic hit;
		hit = 1'b0;
		unique case (guard)
			2'b00: hit = 1'b0;
			2'b01: hit = (addr >= `SEPC_QUARTER_BASE);
			2'b10: hit = (addr >= `SEPC_HALF_BASE);
			2'b11: hit = 1'b1;
		endcase
		return hit;
	endfunction : sepc_guarded

	// next address: whole-array wrap, or wrap inside the 128-byte page
	function automatic logic [15:0] sepc_next_addr(input logic [15:0] addr, input logic in_page);
		logic [15:0] nxt;
		nxt = addr + 16'h0001;
		if (in_page)
		begin
			nxt = {addr[15:7], 7'(addr[6:0] + 7'h01)};
		end
		return nxt;
	endfunction : sepc_next_addr

	// the frame logic is cleared while chip select is high
	assign frame_rst_n = resetn & ~spi_cs_n;

	// marks that the current frame has seen a rising edge; rising logic uses it to restart the bit count
	always_ff @(posedge spi_sck or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			armed_r <= 1'b0;
		end
		else if (spi_hold_n)
		begin
			armed_r <= 1'b1;
		end
	end

	// rising edge: shift in opcode, address and data; the bit count restarts at the frame's first edge
	always_comb
	begin
		logic [5:0] idx;
		logic [2:0] pos;
		logic [7:0] byte_in;
		idx = armed_r ? link_r.cnt : 6'h00;
		pos = armed_r ? link_r.bpos : 3'h0;
		byte_in = {link_r.sh, spi_si};
		link_nxt = link_r;
		// status snapshot from the core clock, two flops per bit
		link_nxt.st_s1 = core_r.st;
		link_nxt.st_s2 = link_r.st_s1;
		// hold pauses shifting; input bits are ignored meanwhile
		if (spi_hold_n)
		begin
			link_nxt.cnt = (idx == `SEPC_CNT_MAX) ? idx : 6'(idx + 6'h01);
			link_nxt.bpos = 3'(pos + 3'h1);
			link_nxt.sh = byte_in[6:0];
			link_nxt.load = 1'b0;
			if (!armed_r)
			begin
				link_nxt.drive = 1'b0;
			end
			if (idx == `SEPC_OP_LAST)
			begin
				link_nxt.op = byte_in;
				if (byte_in == `SEPC_OP_ST_RD)
				begin
					link_nxt.load = 1'b1;
					link_nxt.drive = 1'b1;
				end
			end
			// status read repeats the register every byte
			if (link_r.op == `SEPC_OP_ST_RD && idx > `SEPC_OP_LAST && pos == 3'h7)
			begin
				link_nxt.load = 1'b1;
			end
			if (idx >= `SEPC_ADDR_FIRST && idx <= `SEPC_ADDR_LAST)
			begin
				link_nxt.addr = {link_r.addr[14:0], spi_si};
			end
			if (idx == `SEPC_SW_LAST)
			begin
				link_nxt.sw_data = byte_in;
			end
			// read data starts right after the last address bit, unless busy
			if (idx == `SEPC_ADDR_LAST && link_r.op == `SEPC_OP_MEM_RD && !link_r.st_s2[`SEPC_ST_BUSY])
			begin
				link_nxt.load = 1'b1;
				link_nxt.drive = 1'b1;
			end
			if (idx > `SEPC_ADDR_LAST && pos == 3'h7)
			begin
				if (link_r.op == `SEPC_OP_MEM_RD)
				begin
					link_nxt.load = 1'b1;
					link_nxt.addr = sepc_next_addr(link_r.addr, link_r.st_s2[`SEPC_ST_ID_SEL]);
				end
				if (link_r.op == `SEPC_OP_MEM_WR)
				begin
					link_nxt.wr_data = byte_in;
					link_nxt.wr_addr = link_r.addr;
					link_nxt.wr_tog = ~link_r.wr_tog;
					link_nxt.addr = sepc_next_addr(link_r.addr, 1'b1);
				end
			end
		end
	end

	always_ff @(posedge spi_sck or negedge resetn)
	begin
		if (!resetn)
		begin
			link_r <= '0;
		end
		else
		begin
			link_r <= link_nxt;
		end
	end

	// falling edge: load a byte or shift the next bit out
	always_comb
	begin
		out_nxt = out_r;
		if (armed_r && spi_hold_n)
		begin
			if (link_r.load)
			begin
				out_nxt.sh = (link_r.op == `SEPC_OP_ST_RD) ? link_r.st_s2 : mem_rd_data;
			end
			else
			begin
				out_nxt.sh = {out_r.sh[6:0], 1'b0};
			end
			out_nxt.oe = link_r.drive;
		end
	end

	// cleared the moment chip select rises, so the pin floats between frames
	always_ff @(negedge spi_sck or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			out_r <= '0;
		end
		else
		begin
			out_r <= out_nxt;
		end
	end

	// core clock: protection, status register and self-timed write timer
	always_comb
	begin
		logic frame_start;
		logic frame_end;
		logic byte_evt;
		logic hw_guard;
		logic sw_ok;
		logic mem_ok;
		logic [7:0] d;
		// a byte stays refused until a guard check below allows it
		mem_ok = 1'b0;
		core_nxt = core_r;
		core_nxt.cs_s1 = spi_cs_n;
		core_nxt.cs_s2 = core_r.cs_s1;
		core_nxt.cs_prev = core_r.cs_s2;
		core_nxt.wp_s1 = spi_wp_n;
		core_nxt.wp_s2 = core_r.wp_s1;
		core_nxt.tg_s1 = link_r.wr_tog;
		core_nxt.tg_s2 = core_r.tg_s1;
		core_nxt.tg_prev = core_r.tg_s2;
		core_nxt.mem_wr_valid = 1'b0;
		core_nxt.commit = 1'b0;
		core_nxt.st.zero = 1'b0;
		frame_start = core_r.cs_prev & ~core_r.cs_s2;
		frame_end = ~core_r.cs_prev & core_r.cs_s2 & ~core_r.skip_frame;
		byte_evt = (core_r.tg_s2 != core_r.tg_prev) & ~core_r.skip_frame;
		d = link_r.sw_data;
		hw_guard = core_r.st.guard_en & ~core_r.wp_s2;
		sw_ok = core_r.st.permit & ~hw_guard;
		if (core_r.st.id_sel)
		begin
			mem_ok = core_r.st.permit & ~core_r.st.id_lock & (core_r.st.guard != 2'b11);
		end
		else
		begin
			mem_ok = core_r.st.permit & ~sepc_guarded(core_r.st.guard, link_r.wr_addr);
		end
		// a frame opened while busy is ignored, status read apart
		if (frame_start)
		begin
			core_nxt.skip_frame = core_r.st.busy;
			core_nxt.acc_any = 1'b0;
		end
		// each received data byte is checked against the guards at once
		if (byte_evt && link_r.op == `SEPC_OP_MEM_WR && mem_ok)
		begin
			core_nxt.mem_wr.id = core_r.st.id_sel;
			core_nxt.mem_wr.addr = link_r.wr_addr;
			core_nxt.mem_wr.data = link_r.wr_data;
			core_nxt.mem_wr_valid = 1'b1;
			core_nxt.acc_any = 1'b1;
		end
		// self-timed write; the latch drops when it completes
		if (core_r.st.busy)
		begin
			if (core_r.tcnt == 24'(TWC_CYCLES - 1))
			begin
				core_nxt.st.busy = 1'b0;
				core_nxt.st.permit = 1'b0;
				core_nxt.tcnt = 24'h00_0000;
			end
			else
			begin
				core_nxt.tcnt = 24'(core_r.tcnt + 24'h00_0001);
			end
		end
		// opcode effects take place when chip select closes the frame
		if (frame_end)
		begin
			unique case (link_r.op)
				`SEPC_OP_SET_WL:
				begin
					if (link_r.cnt == 6'h08)
					begin
						core_nxt.st.permit = 1'b1;
					end
				end
				`SEPC_OP_CLR_WL:
				begin
					if (link_r.cnt == 6'h08)
					begin
						core_nxt.st.permit = 1'b0;
					end
				end
				`SEPC_OP_ST_WR:
				begin
					if (link_r.cnt > `SEPC_SW_LAST && sw_ok)
					begin
						core_nxt.st.guard_en = d[`SEPC_ST_GUARD_EN];
						core_nxt.st.guard = d[`SEPC_ST_GUARD_HI:`SEPC_ST_GUARD_LO];
						if (!(d[`SEPC_ST_ID_SEL] && d[`SEPC_ST_ID_LOCK]))
						begin
							core_nxt.st.id_sel = d[`SEPC_ST_ID_SEL];
							core_nxt.st.id_lock = core_r.st.id_lock | d[`SEPC_ST_ID_LOCK];
						end
						core_nxt.st.busy = 1'b1;
						core_nxt.tcnt = 24'h00_0000;
					end
				end
				`SEPC_OP_MEM_RD:
				begin
					if (link_r.cnt > `SEPC_ADDR_LAST)
					begin
						core_nxt.st.id_sel = 1'b0;
					end
				end
				`SEPC_OP_MEM_WR:
				begin
					if (core_r.acc_any)
					begin
						core_nxt.commit = 1'b1;
						core_nxt.st.busy = 1'b1;
						core_nxt.tcnt = 24'h00_0000;
						core_nxt.st.id_sel = 1'b0;
					end
				end
				default:
				begin
					core_nxt.st = core_r.st;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			core_r <= '0;
			core_r.cs_s1 <= 1'b1;
			core_r.cs_s2 <= 1'b1;
			core_r.cs_prev <= 1'b1;
			core_r.st <= `SEPC_STATUS_RST;
		end
		else
		begin
			core_r <= core_nxt;
		end
	end

	// outputs straight from flops
	assign spi_so_o = out_r.sh[7];
	assign spi_so_oe = out_r.oe;
	assign mem_rd_addr = link_r.addr;
	assign mem_rd_id = link_r.st_s2[`SEPC_ST_ID_SEL];
	assign mem_wr = core_r.mem_wr;
	assign mem_wr_valid = core_r.mem_wr_valid;
	assign mem_commit = core_r.commit;
	assign status_o = core_r.st;

endmodule : sepc_top

//--- test/sepc_host.sv
// host spi master model that drives the link clock
`timescale 1ns/1ps
module sepc_host
(
	output logic sck,
	output logic cs_n,
	output logic si,
	output logic hold_n,
	input wire logic so,
	input wire logic so_oe
);
	// idle: clock stands still, chip deselected
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		hold_n = 1'b1;
	end
	// one frame msb first, m3 picks mode 3, a pause runs before bit hb
	task automatic xfer(input logic [63:0] tx, input int n, input bit m3, input int hb, output logic [63:0] rx);
		rx = '0;
		sck = m3;
		#40 cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			#31.25 sck = 1'b0;
			if (i == hb)
			begin
				#10 hold_n = 1'b0;
				// clock edges while paused must be ignored
				repeat (3)
				begin
					#31.25 sck = 1'b1;
					si = ~si;
					#31.25 sck = 1'b0;
				end
				#10 hold_n = 1'b1;
			end
			#31.25 si = tx[i];
			#31.25 sck = 1'b1;
			rx = {rx[62:0], so_oe ? so : 1'bz};
			#31.25;
		end
		sck = m3;
		#31.25 cs_n = 1'b1;
		si = ~si; // no stale level once deselected
		#100;
	endtask : xfer
endmodule : sepc_host

//--- test/sepc_chk.sv
// port assertions of the spi eeprom front end
`timescale 1ns/1ps
module sepc_chk
	import sepc_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic spi_cs_n,
	input wire logic spi_wp_n,
	input wire logic spi_so_oe,
	input sepc_mem_wr_t mem_wr,
	input wire logic mem_wr_valid,
	input wire logic mem_commit,
	input sepc_status_t status_o
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	// status layout and output enable
	zero_bit_a: assert property (status_o.zero == 1'b0) else $error("bit 5 set");
	oe_idle_a: assert property (spi_cs_n && $past(spi_cs_n) |-> !spi_so_oe) else $error("so driven");
	// write permission and guards
	wr_latch_a: assert property (mem_wr_valid |-> status_o.permit) else $error("write w/o latch");
	guard_map_a: assert property (mem_wr_valid && !mem_wr.id |-> status_o.guard == 2'b00
		|| (status_o.guard == 2'b01 && mem_wr.addr[15:14] != 2'b11)
		|| (status_o.guard == 2'b10 && !mem_wr.addr[15])) else $error("guarded write");
	lock_page_a: assert property (mem_wr_valid && mem_wr.id |-> !status_o.id_lock
		&& status_o.guard != 2'b11) else $error("locked page write");
	lock_keep_a: assert property ($past(status_o.id_lock) |-> status_o.id_lock) else $error("lock lost");
	pin_guard_a: assert property ($changed(status_o.guard) |-> spi_wp_n || !$past(status_o.guard_en))
		else $error("guard written under pin");
	// self-timed write
	commit_busy_a: assert property (mem_commit |-> ##[0:1] status_o.busy) else $error("no busy");
	busy_end_a: assert property ($fell(status_o.busy) |-> !status_o.permit) else $error("latch kept");
	busy_quiet_a: assert property (status_o.busy |-> !mem_wr_valid) else $error("write while busy");
	sel_clear_a: assert property (mem_commit |-> ##[0:1] !status_o.id_sel) else $error("sel kept");
endmodule : sepc_chk

bind sepc_top sepc_chk u_chk (.core_clk(core_clk), .resetn(resetn), .spi_cs_n(spi_cs_n), .spi_wp_n(spi_wp_n),
	.spi_so_oe(spi_so_oe), .mem_wr(mem_wr), .mem_wr_valid(mem_wr_valid), .mem_commit(mem_commit),
	.status_o(status_o));

//--- test/spi_eeprom_command_protect_bench.sv
// self-checking bench of the spi eeprom front end
`timescale 1ns/1ps
module spi_eeprom_command_protect_bench import sepc_pkg::*;;
	typedef struct packed {logic [15:0] tx; logic [4:0] n; logic wp; logic [7:0] ex;} sepc_row_t;
	logic core_clk, resetn, sck, cs_n, si, hold_n, wp_n, so, oe, rd_id, wr_v, commit;
	logic [15:0] rd_addr;
	logic [63:0] rx;
	sepc_mem_wr_t wr, lw;
	sepc_status_t st;
	int errors = 0;
	int total_checks = 0;
	int nw = 0;
	int n0;
	// frame, pin, status expected after the self-timed cycle
	sepc_row_t rows [12] = '{'{16'h0006, 5'd8, 1'b1, 8'h02}, '{16'h0004, 5'd8, 1'b1, 8'h00},
		'{16'h0006, 5'd8, 1'b1, 8'h02}, '{16'h018c, 5'd16, 1'b1, 8'h8c}, '{16'h0006, 5'd8, 1'b1, 8'h8e},
		'{16'h0100, 5'd16, 1'b0, 8'h8e}, '{16'h0100, 5'd16, 1'b1, 8'h00}, '{16'h0006, 5'd8, 1'b1, 8'h02},
		'{16'h01ff, 5'd16, 1'b1, 8'h8c}, '{16'h0006, 5'd8, 1'b1, 8'h8e}, '{16'h0100, 5'd16, 1'b1, 8'h00},
		'{16'h00aa, 5'd8, 1'b1, 8'h00}};
	// array stand-in answers from the address alone
	sepc_top #(.TWC_CYCLES(400)) uut (.core_clk(core_clk), .resetn(resetn), .spi_sck(sck), .spi_cs_n(cs_n),
		.spi_si(si), .spi_hold_n(hold_n), .spi_wp_n(wp_n), .spi_so_o(so), .spi_so_oe(oe), .mem_rd_addr(rd_addr),
		.mem_rd_id(rd_id), .mem_rd_data(rd_addr[7:0] ^ 8'h5a), .mem_wr(wr), .mem_wr_valid(wr_v),
		.mem_commit(commit), .status_o(st));
	sepc_host host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(oe));
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// count accepted write bytes at the falling edge, clear of the edge that launches them
	always @(negedge core_clk)
	if (wr_v === 1'b1)
	begin
		nw++;
		lw = wr;
	end
	task automatic chk(input logic [24:0] got, input logic [24:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		if (errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop
	// frame, then bounded wait until busy is gone
	task automatic fr(input logic [63:0] tx, input int n);
		int k;
		host.xfer(tx, n, 1'b0, -1, rx);
		repeat (8) @(posedge core_clk);
		for (k = 0; k < 600 && st.busy !== 1'b0; k++)
			@(posedge core_clk);
		if (k == 600)
		begin
			errors++;
			report_and_stop();
		end
	endtask : fr
	initial
	begin
		resetn = 1'b0;
		wp_n = 1'b1;
		repeat (12) @(posedge core_clk);
		#1 resetn = 1'b1;
		repeat (4) @(posedge core_clk);
		foreach (rows[i])
		begin
			#1 wp_n = rows[i].wp;
			fr(64'(rows[i].tx), int'(rows[i].n));
			chk(25'(st), 25'(rows[i].ex));
		end
		fr(64'h0200_1055, 32);
		chk(25'(nw), 25'd0);
		fr(64'h06, 8);
		host.xfer(64'h02_007f_1122, 40, 1'b0, -1, rx);
		host.xfer(64'h0500, 16, 1'b0, -1, rx);
		chk(25'(rx[7:0]), 25'h03);
		fr(64'h06, 8);
		chk(25'(st), 25'h00);
		chk(25'(nw), 25'd2);
		chk(lw, {1'b0, 16'h0000, 8'h22});
		fr(64'h06, 8);
		fr(64'h0104, 16);
		fr(64'h06, 8);
		n0 = nw;
		fr(64'h02c0_00aa, 32);
		fr(64'h02bf_ff77, 32);
		chk(25'(nw - n0), 25'd1);
		chk(lw, {1'b0, 16'hbfff, 8'h77});
		host.xfer(64'h03_1234_0000, 40, 1'b0, -1, rx);
		chk(25'(rx[15:0]), 25'h6e6f);
		host.xfer(64'h0500, 16, 1'b1, 10, rx);
		chk(25'(rx[7:0]), 25'h04);
		fr(64'h06, 8);
		fr(64'h0144, 16);
		fr(64'h06, 8);
		fr(64'h0200_053c, 32);
		chk(lw, {1'b1, 16'h0005, 8'h3c});
		chk(25'(st.id_sel), 25'd0);
		fr(64'h06, 8);
		fr(64'h0114, 16);
		fr(64'h06, 8);
		fr(64'h0144, 16);
		fr(64'h06, 8);
		n0 = nw;
		fr(64'h0200_053c, 32);
		chk(25'(nw - n0), 25'd0);
		fr(64'h03_007f_0000, 40);
		chk(25'(rx[15:0]), 25'h255a);
		chk(25'(rd_id), 25'd1);
		chk(25'(st.id_sel), 25'd0);
		#1 resetn = 1'b0;
		repeat (12) @(posedge core_clk);
		chk(25'(st), 25'h00);
		#1 resetn = 1'b1;
		report_and_stop();
	end
endmodule : spi_eeprom_command_protect_bench
